/* hdl/pbm_buffer_manager.sv */
// Purpose: packet buffer manager, arbitrating host, transmitter and receiver
// Assumes: transmitter and receiver logic on clk; backoff timing kept by the transmitter
// Notes: one memory access per clock, receiver first, then transmitter, then host
// Notes on behaviour
// R1: host, transmitter and receiver share memory, interleaved, each with a holding stage.
// R2: two-bit size field picks one 2 KB buffer or two 2/4/8 KB banks.
// R3: dual banks let host fill one while the other sends; single shares in time.
// R4: host writes step the write pointer forward only, from bank start at reset.
// R5: host writes packet count and start bit; banks swap, sending starts soon.
// R6: read pointer walks the sent bank; collision resends the packet from its header.
// R7: all packets go out in order; then stop, set done status.
// R8: host puts a two-byte 11-bit length header before each transmit packet.
// R9: enabled receiver stores clean, address-matched frames into the ring.
// R10: ring overflow stops reception; it resumes once room is freed.
// R11: receive ring is all memory above the transmit area.
// R12: receive packets start on eight-byte boundaries after a four-byte header.
// R13: empty flag shows waiting packets; host reads advance and free the ring.
// R14: a frame that cannot fit is rejected; stored packets never overwritten.
// R15: bad frames are dropped unless errored frames are accepted, then flagged.
// R16: frames under 60 bytes kept only when runt acceptance is set.
// R17: skip bit discards the rest of the packet within 300 ns, reads zero after.
// R18: receive header is status byte, zero byte, then two length bytes.
// R19: header status bits 1-4 copy frame status, bit 5 good, others zero.
// R20: stored length counts bytes of address, type and data fields only.
// R21: receive write and read pointers wrap from ring end to ring start.
// R22: total memory is 8 KB or 32 KB.
// R23: host buffer port cycles wait for memory instead of losing data; write data taken while a port write waits overwrite its held byte.
// R24: receiver and transmitter win arbitration so their stages never overrun.
//
// Chosen here: register access over AXI4-Lite and the address map.
module pbm_buffer_manager
	import pbm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rxFrameStart,
	input  wire logic        rxByteValid,
	input  wire logic [7:0]  rxByte,
	input  wire logic        rxFrameEnd,
	input  wire pbm_rx_end_t rxEndInfo,
	output pbm_tx_out_t      txOut,
	input  wire logic        txReady,
	input  wire logic        txRetry,
	output logic             txBusy,
	output logic             txChainDone,
	output logic             rxStopped
);
	localparam int skipCycles = PBM_SKIP_NS / PBM_CLK_NS;

	pbm_state_t  st;
	pbm_state_t  next_st;
	logic        memEn;
	logic        memWe;
	logic [14:0] memA;
	logic [7:0]  memD;
	logic [7:0]  memQ;
	logic        hostWrGo;

	function automatic logic [15:0] bankSz(input logic [1:0] sz);
		case (sz) // R2
			2'h0, 2'h1: return PBM_KB2;
			2'h2:       return PBM_KB2 << 1;
			default:    return PBM_KB8;
		endcase
	endfunction

	function automatic logic [15:0] txArea(input logic [1:0] sz);
		return (sz == PBM_TXSZ_SINGLE) ? PBM_KB2 : (bankSz(sz) << 1);
	endfunction

	function automatic logic [14:0] txAddr(input logic bank, input logic [13:0] off, input logic [1:0] sz);
		logic [15:0] b;
		b = bankSz(sz);
		return 15'((bank ? b : 16'h0000) + ({2'b00, off} & (b - 16'h0001)));
	endfunction

	// wrap inside [base, top); optional round up to an eight-byte page
	function automatic logic [14:0] ringAdd(input logic [14:0] p, input logic [15:0] n,
			input logic [15:0] base, input logic [15:0] top, input logic al);
		logic [16:0] s;
		s = {2'b00, p} + {1'b0, n};
		if (al && s[2:0] != 3'h0) begin // R12
			s = {14'(s[16:3] + 14'h0001), 3'h0};
		end
		if (s >= {1'b0, top}) begin // R21
			s = s - {1'b0, top - base};
		end
		return s[14:0];
	endfunction

	pbm_sram u_sram (
		.clk  (clk),
		.en   (memEn),
		.we   (memWe),
		.addr (memA),
		.wdata(memD),
		.rdata(memQ)
	);

	always_comb begin
		logic [15:0] top;
		logic [15:0] base;
		logic [15:0] ring;
		logic [15:0] used;
		logic        dual;
		logic        pktInc;
		logic        pktDec;
		logic        txFetch;
		logic        runt;
		logic        good;
		logic        fin;
		logic [7:0]  rb;
		top = st.mem32 ? PBM_KB32 : PBM_KB8; // R22
		base = txArea(st.txSize); // R11
		ring = top - base;
		used = 16'h0000;
		if (st.pktCnt != 11'h000) begin
			used = (st.rxCw >= st.rxRr) ? 16'(st.rxCw - st.rxRr) : 16'(ring + st.rxCw - st.rxRr);
		end
		dual = st.txSize != PBM_TXSZ_SINGLE;
		pktInc = 1'b0;
		pktDec = 1'b0;
		fin = 1'b0;
		txFetch = 1'b0;
		runt = 1'b0;
		good = 1'b0;
		rb = 8'h00;
		next_st = st;
		next_st.doneP = 1'b0;
		next_st.own = OWN_NONE;
		memEn = 1'b0;
		memWe = 1'b0;
		memA = 15'h0000;
		memD = 8'h00;
		hostWrGo = 1'b0;

		// register bus, write side
		if (s_axi_awvalid && st.awready) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.wHeld = 1'b1;
			next_st.wByte = s_axi_wdata[7:0];
			next_st.wLane = s_axi_wstrb[0];
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.awHeld && st.wHeld && !st.bvalid && !st.hostWr) begin
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = PBM_RESP_OKAY;
			case (st.awAddr)
				PBM_OFF_PORT: begin
					if (st.wLane) begin
						next_st.hostWr = 1'b1; // R23
						next_st.bvalid = 1'b0;
					end
				end
				PBM_OFF_TXCTL: begin
					if (st.wLane) begin
						next_st.mem32 = st.wByte[PBM_TXC_MEM32];
						next_st.txSize = st.wByte[PBM_TXC_SIZE +: 2]; // R2
						if (st.wByte[PBM_TXC_DONE]) begin
							next_st.chainDone = 1'b0;
						end
					end
				end
				PBM_OFF_TXSTART: begin
					if (st.wLane && st.wByte[PBM_TXS_GO]) begin
						next_st.startPend = 1'b1; // R5
						next_st.startCnt = st.wByte[6:0];
					end
				end
				PBM_OFF_RXMODE: begin
					if (st.wLane) begin
						next_st.rxEn = st.wByte[PBM_RXM_EN];
						next_st.accRunt = st.wByte[PBM_RXM_RUNT];
						next_st.accBad = st.wByte[PBM_RXM_BAD];
					end
				end
				PBM_OFF_SKIP: begin
					if (st.wLane && st.wByte[PBM_SKIP_BIT]) begin
						next_st.skipPend = 1'b1; // R17
					end
				end
				PBM_OFF_RXSTAT: begin
					if (st.wLane && st.wByte[PBM_RXS_OVF]) begin
						next_st.ovFlag = 1'b0;
					end
				end
				default: next_st.bresp = PBM_RESP_SLVERR;
			endcase
		end

		// register bus, read side
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = PBM_RESP_OKAY;
			case (s_axi_araddr)
				PBM_OFF_PORT: begin
					next_st.hostRd = 1'b1; // R23
					next_st.rvalid = 1'b0;
				end
				PBM_OFF_TXCTL: begin
					rb[PBM_TXC_MEM32] = st.mem32;
					rb[PBM_TXC_SIZE +: 2] = st.txSize;
					rb[PBM_TXC_DONE] = st.chainDone;
				end
				PBM_OFF_TXSTART: rb = {st.startPend, st.pktLeft};
				PBM_OFF_RXMODE: begin
					rb[PBM_RXM_EN] = st.rxEn;
					rb[PBM_RXM_RUNT] = st.accRunt;
					rb[PBM_RXM_BAD] = st.accBad;
					rb[PBM_RXM_EMPTY] = st.pktCnt == 11'h000; // R13
				end
				PBM_OFF_SKIP: rb[PBM_SKIP_BIT] = st.skipPend; // R17
				PBM_OFF_RXSTAT: rb = {3'h0, st.lastStat, st.ovFlag}; // R19
				default: next_st.rresp = PBM_RESP_SLVERR;
			endcase
			next_st.rdata = {24'h00_0000, rb};
		end

		// memory data returning from last cycle's read
		if (st.own == OWN_TX) begin
			next_st.trp = st.trp + 14'h0001; // R6
			case (st.txSt)
				TX_LEN0: begin
					next_st.lenLo = memQ;
					next_st.txSt = TX_LEN1;
				end
				TX_LEN1: begin
					next_st.byteLeft = {memQ[2:0], st.lenLo}; // R8
					next_st.txSt = TX_DATA;
				end
				default: begin
					next_st.txo = '{valid: 1'b1, last: st.byteLeft == 11'h001, data: memQ};
					next_st.byteLeft = st.byteLeft - 11'h001;
				end
			endcase
		end
		if (st.own == OWN_HOST || st.own == OWN_SKIP) begin
			if (st.own == OWN_HOST) begin
				next_st.hostRd = 1'b0;
				next_st.rvalid = 1'b1;
				next_st.rdata = {24'h00_0000, memQ};
			end
			if (st.rdIdx == 3'h2) begin
				next_st.rdLenLo = memQ;
			end
			if (st.rdIdx == 3'h3) begin
				next_st.rdLeft = {memQ[2:0], st.rdLenLo};
				fin = {memQ[2:0], st.rdLenLo} == 11'h000;
			end
			if (st.rdIdx == 3'h4) begin
				next_st.rdLeft = st.rdLeft - 11'h001;
				fin = st.rdLeft == 11'h001;
			end else begin
				next_st.rdIdx = st.rdIdx + 3'h1;
			end
			next_st.rxRr = ringAdd(st.rxRr, 16'h0001, base, top, fin); // R13
			if (fin) begin
				next_st.rdIdx = 3'h0;
				pktDec = 1'b1;
			end
		end

		// transmitter
		txFetch = !st.retryPend && st.own != OWN_TX && (st.txSt == TX_LEN0 || st.txSt == TX_LEN1 ||
			(st.txSt == TX_DATA && st.byteLeft != 11'h000 && !st.txo.valid));
		if (st.txo.valid && txReady) begin
			next_st.txo.valid = 1'b0;
		end
		if (st.txSt == TX_DATA && st.byteLeft == 11'h000 && !st.txo.valid && st.own != OWN_TX) begin
			next_st.pktStart = st.trp;
			next_st.pktLeft = st.pktLeft - 7'h01;
			next_st.txSt = TX_LEN0; // R7
			if (st.pktLeft == 7'h01) begin
				next_st.txSt = TX_IDLE;
				next_st.chainDone = 1'b1;
				next_st.doneP = 1'b1;
			end
		end
		if (st.txSt == TX_IDLE && st.startPend) begin
			next_st.startPend = 1'b0;
			next_st.pktLeft = st.startCnt;
			next_st.sendBank = dual & st.hostBank; // R3
			next_st.hostBank = dual & ~st.hostBank;
			next_st.twp = 14'h0000;
			next_st.trp = 14'h0000;
			next_st.pktStart = 14'h0000;
			next_st.txSt = TX_LEN0; // R5
			if (st.startCnt == 7'h00) begin
				next_st.txSt = TX_IDLE;
				next_st.chainDone = 1'b1;
			end
		end
		// the resend waits for any fetch in flight, so stale data never lands as a length byte
		next_st.retryPend = st.retryPend;
		if (st.retryPend && st.own != OWN_TX) begin
			next_st.retryPend = 1'b0;
			if (st.txSt != TX_IDLE) begin
				next_st.trp = st.pktStart; // R6
				next_st.txSt = TX_LEN0;
				next_st.txo.valid = 1'b0;
			end
		end
		if (txRetry) begin
			next_st.retryPend = 1'b1;
		end

		// arbitration: one access per cycle, receiver first
		if (st.holdV) begin // R24
			memEn = 1'b1;
			memWe = 1'b1;
			memA = st.holdA;
			memD = st.holdB;
			next_st.holdV = 1'b0;
		end else if (st.rxSt == RX_HDR) begin
			memEn = 1'b1; // R1
			memWe = 1'b1;
			memA = ringAdd(st.rxPkt, {14'h0000, st.hdrIdx}, base, top, 1'b0);
			case (st.hdrIdx) // R18
				2'h0: memD = st.hdrStat;
				2'h1: memD = 8'h00;
				2'h2: memD = st.rxLen[7:0]; // R20
				default: memD = {5'h00, st.rxLen[10:8]};
			endcase
			next_st.hdrIdx = st.hdrIdx + 2'h1;
			if (st.hdrIdx == 2'h3) begin
				next_st.rxCw = ringAdd(st.rxWp, 16'h0000, base, top, 1'b1); // R12
				next_st.rxSt = RX_IDLE;
				pktInc = 1'b1;
			end
		end else if (txFetch) begin
			memEn = 1'b1;
			memA = txAddr(st.sendBank, st.trp, st.txSize); // R6
			next_st.own = OWN_TX;
		end else if (st.hostWr && (dual || st.txSt == TX_IDLE)) begin
			hostWrGo = 1'b1;
			memEn = 1'b1; // R3
			memWe = 1'b1;
			memA = txAddr(st.hostBank, st.twp, st.txSize);
			memD = st.wByte;
			next_st.twp = 14'((bankSz(st.txSize) - 16'h0001) & {2'b00, st.twp + 14'h0001}); // R4
			next_st.hostWr = 1'b0;
			next_st.bvalid = 1'b1;
		end else if (st.own != OWN_HOST && st.own != OWN_SKIP && st.pktCnt != 11'h000 &&
				(st.hostRd || (st.skipPend && st.rdIdx != 3'h4))) begin
			memEn = 1'b1; // R23
			memA = st.rxRr;
			next_st.own = st.hostRd ? OWN_HOST : OWN_SKIP;
		end
		// reads of an empty ring answer zero at once and move nothing
		if (st.hostRd && st.pktCnt == 11'h000 && st.own != OWN_HOST && st.own != OWN_SKIP) begin
			next_st.hostRd = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rdata = 32'h0000_0000;
		end
		if (st.skipPend && !st.hostRd && st.own != OWN_HOST && st.own != OWN_SKIP) begin
			if (st.pktCnt == 11'h000) begin
				next_st.skipPend = 1'b0;
			end else if (st.rdIdx == 3'h4) begin
				next_st.rxRr = ringAdd(st.rxRr, {5'h00, st.rdLeft}, base, top, 1'b1); // R17
				next_st.rdIdx = 3'h0;
				next_st.skipPend = 1'b0;
				pktDec = 1'b1;
			end
		end

		// an empty ring left below a new transmit area restarts at the ring base
		if (st.pktCnt == 11'h000 && st.rxSt == RX_IDLE && {1'b0, st.rxRr} < base) begin
			next_st.rxCw = base[14:0]; // R11
			next_st.rxRr = base[14:0];
		end

		// receiver
		if (rxFrameStart && st.rxSt != RX_HDR) begin
			next_st.rxSt = RX_DROP;
			if (st.rxEn && !st.ovStop) begin
				next_st.rxSt = RX_DATA; // R9
				next_st.rxPkt = st.rxCw;
				next_st.rxWp = ringAdd(st.rxCw, PBM_HDR_BYTES, base, top, 1'b0);
				next_st.rxLen = 11'h000;
			end
		end else if (rxByteValid && st.rxSt == RX_DATA) begin
			if (used + {5'h00, st.rxLen} + PBM_HDR_BYTES + PBM_GUARD >= ring) begin
				next_st.rxSt = RX_DROP; // R14
				next_st.ovFlag = 1'b1; // R10
				next_st.ovStop = 1'b1;
			end else if (st.rxLen == PBM_MAX_LEN) begin
				next_st.rxSt = RX_DROP;
			end else begin
				next_st.holdV = 1'b1; // R1
				next_st.holdB = rxByte;
				next_st.holdA = st.rxWp;
				next_st.rxWp = ringAdd(st.rxWp, 16'h0001, base, top, 1'b0); // R21
				next_st.rxLen = st.rxLen + 11'h001; // R20
			end
		end else if (rxFrameEnd && st.rxSt == RX_DROP) begin
			next_st.rxSt = RX_IDLE;
		end else if (rxFrameEnd && st.rxSt == RX_DATA) begin
			runt = st.rxLen < PBM_MIN_LEN;
			good = !rxEndInfo.crcErr && !rxEndInfo.alignErr && !runt;
			next_st.lastStat = {rxEndInfo.remoteType, runt, rxEndInfo.alignErr, rxEndInfo.crcErr}; // R19
			next_st.hdrStat = {2'b00, good, rxEndInfo.remoteType, runt, rxEndInfo.alignErr,
				rxEndInfo.crcErr, 1'b0}; // R19
			next_st.hdrIdx = 2'h0;
			next_st.rxSt = RX_IDLE; // R15
			if (rxEndInfo.addrMatch && (good || st.accBad || (!rxEndInfo.crcErr && !rxEndInfo.alignErr))
					&& (!runt || st.accRunt)) begin
				next_st.rxSt = RX_HDR; // R16
			end
		end
		if (st.ovStop && st.rxSt != RX_DATA && ring - used > PBM_RESUME_ROOM) begin
			next_st.ovStop = 1'b0; // R10
		end

		case ({pktInc, pktDec})
			2'b10:   next_st.pktCnt = st.pktCnt + 11'h001;
			2'b01:   next_st.pktCnt = st.pktCnt - 11'h001;
			default: next_st.pktCnt = st.pktCnt;
		endcase
		next_st.awready = !next_st.awHeld;
		next_st.wready = !next_st.wHeld;
		next_st.arready = !next_st.hostRd && !next_st.rvalid;
		next_st.txBusy = next_st.txSt != TX_IDLE;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready  = st.wready;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rresp   = st.rresp;
	assign s_axi_rdata   = st.rdata;
	assign txOut         = st.txo;
	assign txBusy        = st.txBusy;
	assign txChainDone   = st.doneP;
	assign rxStopped     = st.ovStop;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence skipAsked;
		$rose(st.skipPend);
	endsequence
	sequence skipFinished;
		##[1:skipCycles] !st.skipPend;
	endsequence
	sequence txAccept;
		st.startPend && st.txSt == TX_IDLE && st.txSize != PBM_TXSZ_SINGLE;
	endsequence

	skipBound_a: assert property (skipAsked |-> skipFinished) // R17
		else $error("skip not finished in time");
	bankSwap_a: assert property (txAccept |=> st.hostBank != $past(st.hostBank) && st.sendBank == $past(st.hostBank)) // R3
		else $error("banks not swapped on start");
	txStart_a: assert property (st.startPend && st.txSt == TX_IDLE |=> !st.startPend && st.pktLeft == $past(st.startCnt)) // R5
		else $error("start not taken");
	holdFirst_a: assert property (st.holdV |-> memEn && memWe && memA == st.holdA) // R24
		else $error("receive byte not served first");
	stopRx_a: assert property (st.ovStop |-> st.rxSt != RX_DATA) // R10
		else $error("reception during overflow");
	hostWrite_a: assert property (hostWrGo |-> memWe ##1 st.twp != $past(st.twp) && st.bvalid) // R4
		else $error("write pointer not advanced");
	dropBad_a: assert property (rxFrameEnd && st.rxSt == RX_DATA && rxEndInfo.crcErr && !st.accBad
		|=> st.rxSt == RX_IDLE) // R15
		else $error("bad frame kept");
	dropRunt_a: assert property (rxFrameEnd && st.rxSt == RX_DATA && st.rxLen < PBM_MIN_LEN && !st.accRunt
		|=> st.rxSt == RX_IDLE) // R16
		else $error("short frame kept");
	hdrStatus_a: assert property (st.rxSt == RX_HDR && !st.holdV && st.hdrIdx == 2'h0
		|-> memD[0] == 1'b0 && memD[7:6] == 2'b00 && memD[5] == !(|memD[3:1])) // R19
		else $error("bad header status byte");
	pageAlign_a: assert property (st.rxSt == RX_HDR && !st.holdV && st.hdrIdx == 2'h3
		|=> st.rxCw[2:0] == 3'h0 && st.pktCnt != 11'h000) // R12
		else $error("packet not page aligned");
endmodule

/* hdl/pbm_pkg.sv */
// Purpose: shared constants and types of the packet buffer manager
// Assumes: byte-wide packet memory, AXI4-Lite register access, one clock
// Notes: register offsets are byte addresses of aligned 32-bit words
package pbm_pkg;
	localparam logic [7:0]  PBM_OFF_PORT    = 8'h00;
	localparam logic [7:0]  PBM_OFF_TXCTL   = 8'h04;
	localparam logic [7:0]  PBM_OFF_TXSTART = 8'h08;
	localparam logic [7:0]  PBM_OFF_RXMODE  = 8'h0c;
	localparam logic [7:0]  PBM_OFF_SKIP    = 8'h10;
	localparam logic [7:0]  PBM_OFF_RXSTAT  = 8'h14;
	localparam int          PBM_TXC_MEM32   = 0;
	localparam int          PBM_TXC_SIZE    = 2;
	localparam int          PBM_TXC_DONE    = 7;
	localparam int          PBM_TXS_GO      = 7;
	localparam int          PBM_RXM_EN      = 0;
	localparam int          PBM_RXM_RUNT    = 3;
	localparam int          PBM_RXM_BAD     = 5;
	localparam int          PBM_RXM_EMPTY   = 6;
	localparam int          PBM_SKIP_BIT    = 2;
	localparam int          PBM_RXS_OVF     = 0;
	localparam logic [1:0]  PBM_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  PBM_RESP_SLVERR = 2'h2;
	localparam logic [1:0]  PBM_TXSZ_SINGLE = 2'h0;
	localparam logic [15:0] PBM_KB2         = 16'h0800;
	localparam logic [15:0] PBM_KB8         = 16'h2000;
	localparam logic [15:0] PBM_KB32        = 16'h8000;
	localparam logic [15:0] PBM_HDR_BYTES   = 16'h0004;
	localparam logic [15:0] PBM_GUARD       = 16'h0008;
	localparam logic [15:0] PBM_RESUME_ROOM = 16'h0610;
	localparam logic [10:0] PBM_MIN_LEN     = 11'h03c;
	localparam logic [10:0] PBM_MAX_LEN     = 11'h7ff;
	localparam int          PBM_CLK_NS      = 10;
	localparam int          PBM_SKIP_NS     = 300;
	localparam int          PBM_MEM_AW      = 15;

	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LEN0 = 2'b01, TX_LEN1 = 2'b10, TX_DATA = 2'b11} pbm_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_DATA = 2'b01, RX_DROP = 2'b10, RX_HDR = 2'b11} pbm_rx_st_t;
	typedef enum logic [1:0] {OWN_NONE = 2'b00, OWN_TX = 2'b01, OWN_HOST = 2'b10, OWN_SKIP = 2'b11} pbm_own_t;

	typedef struct packed {
		logic crcErr;
		logic alignErr;
		logic addrMatch;
		logic remoteType;
	} pbm_rx_end_t;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} pbm_tx_out_t;

	typedef struct packed {
		logic        awHeld;
		logic [7:0]  awAddr;
		logic        wHeld;
		logic [7:0]  wByte;
		logic        wLane;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        hostRd;
		logic        hostWr;
		logic [1:0]  txSize;
		logic        mem32;
		logic        rxEn;
		logic        accBad;
		logic        accRunt;
		logic        hostBank;
		logic [13:0] twp;
		logic        startPend;
		logic [6:0]  startCnt;
		logic        chainDone;
		logic        doneP;
		logic        txBusy;
		pbm_tx_st_t  txSt;
		logic        sendBank;
		logic [6:0]  pktLeft;
		logic [13:0] trp;
		logic [13:0] pktStart;
		logic [7:0]  lenLo;
		logic [10:0] byteLeft;
		logic        retryPend;
		pbm_tx_out_t txo;
		pbm_rx_st_t  rxSt;
		logic [14:0] rxPkt;
		logic [14:0] rxWp;
		logic [10:0] rxLen;
		logic        holdV;
		logic [7:0]  holdB;
		logic [14:0] holdA;
		logic [7:0]  hdrStat;
		logic [1:0]  hdrIdx;
		logic [14:0] rxCw;
		logic [14:0] rxRr;
		logic [10:0] pktCnt;
		logic        ovFlag;
		logic        ovStop;
		logic [3:0]  lastStat;
		logic [2:0]  rdIdx;
		logic [7:0]  rdLenLo;
		logic [10:0] rdLeft;
		logic        skipPend;
		pbm_own_t    own;
	} pbm_state_t;
endpackage

/* hdl/pbm_sram.sv */
// Purpose: byte-wide packet memory, one access per clock
// Assumes: read data valid one cycle after the enable
// Notes: read data come from a register
module pbm_sram
	import pbm_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  en,
	input  wire logic                  we,
	input  wire logic [PBM_MEM_AW-1:0] addr,
	input  wire logic [7:0]            wdata,
	output logic      [7:0]            rdata
);
	logic [7:0] mem [0:(1<<PBM_MEM_AW)-1];

	always_ff @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
		if (en && !we) begin
			rdata <= mem[addr];
		end
	end
endmodule

/* testbench/pbm_mac_model.sv */
// Purpose: link-side model, frames in, byte sink out
// Assumes: one receive byte per 9 clocks
// Notes: txReady toggles so fetches see stalls
module pbm_mac_model
	import pbm_pkg::*;
(
	input  wire logic        clk,
	input  wire pbm_tx_out_t txOut,
	output logic             txReady,
	output logic             rxFrameStart,
	output logic             rxByteValid,
	output logic [7:0]       rxByte,
	output logic             rxFrameEnd,
	output pbm_rx_end_t      rxEndInfo
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {txReady, rxFrameStart, rxByteValid, rxByte, rxFrameEnd, rxEndInfo} = '0;
	always @(posedge clk) txReady <= ~txReady;
	task automatic send(input logic [63:0] b, input int n, input pbm_rx_end_t info);
		int i;
		@(posedge clk) rxFrameStart <= 1;
		@(posedge clk) rxFrameStart <= 0;
		for (i = 0; i < n; i++) begin
			repeat (8) @(posedge clk);
			{rxByte, rxByteValid} <= {b[8*i+:8], 1'h1};
			@(posedge clk) rxByteValid <= 0;
			// stale byte never left on the lines
			rxByte <= ~rxByte;
		end
		repeat (8) @(posedge clk);
		{rxFrameEnd, rxEndInfo} <= {1'h1, info};
		@(posedge clk) rxFrameEnd <= 0;
	endtask
endmodule

/* testbench/testbench.sv */
// Purpose: self-checking bench of the buffer manager
// Assumes: one clock, link model on the far side
// Notes: drivers queue expectations, a monitor compares
`define CHK(a, b) begin total_checks++; got = 34'(a); want = 34'(b); \
	if (got !== want) begin failures++; $display("BAD %0t mismatch %h %h", $time, got, want); end end
module testbench
	import pbm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, txRetry;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic rxFrameStart, rxByteValid, rxFrameEnd, txReady, txBusy, txChainDone, rxStopped;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rxByte, d;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [63:0] pkt;
	logic [33:0] got, want;
	pbm_rx_end_t rxEndInfo;
	pbm_tx_out_t txOut;
	int failures, total_checks, seed, n;
	logic [33:0] expR[$];
	logic [8:0] expT[$];
	pbm_buffer_manager pbm_buffer_manager_i (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.rxFrameStart, .rxByteValid, .rxByte, .rxFrameEnd, .rxEndInfo, .txOut, .txReady, .txRetry, .txBusy,
		.txChainDone, .rxStopped);
	pbm_mac_model pbm_mac_model_i (.clk, .txOut, .txReady, .rxFrameStart, .rxByteValid, .rxByte, .rxFrameEnd,
		.rxEndInfo);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic bad;
		failures++;
		test_done();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic ad, dd;
		int i;
		{ad, dd, i} = '0;
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, 24'h00_0000, v, 2'h3};
		do begin
			@(posedge clk);
			ad |= s_axi_awready;
			dd |= s_axi_wready;
			if (ad) s_axi_awvalid <= 0;
			if (dd) s_axi_wvalid <= 0;
		end while (!(ad && dd) && ++i < 100);
		do @(posedge clk); while (!s_axi_bvalid && ++i < 200);
		if (i >= 200) bad();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = PBM_RESP_OKAY);
		int i;
		i = 0;
		@(posedge clk);
		{s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
		expR.push_back({r, 24'h00_0000, v});
		do @(posedge clk); while (!s_axi_arready && ++i < 100);
		s_axi_arvalid <= 0;
		do @(posedge clk); while (!s_axi_rvalid && ++i < 200);
		if (i >= 200) bad();
	endtask
	task automatic txSend(input int k);
		wr(PBM_OFF_PORT, 8'(k));
		wr(PBM_OFF_PORT, 8'h00);
		for (n = 0; n < k; n++) begin
			d = 8'($random(seed));
			expT.push_back({n == k - 1, d});
			wr(PBM_OFF_PORT, d);
		end
		wr(PBM_OFF_TXSTART, 8'h81);
		n = 0;
		do @(posedge clk); while (!txChainDone && ++n < 500);
		if (n >= 500) bad();
		`CHK(txBusy, 1'h0)
	endtask
	always @(posedge clk) begin
		if (s_axi_rvalid) `CHK({s_axi_rresp, s_axi_rdata}, expR.size() ? expR.pop_front() : 'x)
		if (txOut.valid && txReady) `CHK({txOut.last, txOut.data}, expT.size() ? expT.pop_front() : 'x)
		if (s_axi_bvalid) `CHK(s_axi_bresp, PBM_RESP_OKAY)
	end
	initial begin
		{srst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, txRetry} = 5'h10;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, failures, total_checks} = '0;
		{s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h07;
		seed = 47;
		repeat (6) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		rd(PBM_OFF_TXCTL, 8'h00);
		rd(PBM_OFF_RXMODE, 8'h40);
		rd(8'h20, 8'h00, PBM_RESP_SLVERR);
		$display("reset test done");
		txSend(3);
		rd(PBM_OFF_TXCTL, 8'h80);
		wr(PBM_OFF_TXCTL, 8'h84);
		txSend(1);
		rd(PBM_OFF_TXCTL, 8'h84);
		$display("transmit test done");
		wr(PBM_OFF_RXMODE, 8'h09);
		pkt = {$random(seed), $random(seed)};
		pbm_mac_model_i.send(pkt, 4, 4'h2);
		repeat (20) @(posedge clk);
		rd(PBM_OFF_RXMODE, 8'h09);
		rd(PBM_OFF_RXSTAT, 8'h08);
		rd(PBM_OFF_PORT, 8'h08);
		rd(PBM_OFF_PORT, 8'h00);
		rd(PBM_OFF_PORT, 8'h04);
		rd(PBM_OFF_PORT, 8'h00);
		for (n = 0; n < 4; n++) rd(PBM_OFF_PORT, pkt[8*n+:8]);
		rd(PBM_OFF_RXMODE, 8'h49);
		pbm_mac_model_i.send(pkt, 4, 4'ha);
		repeat (20) @(posedge clk);
		rd(PBM_OFF_RXMODE, 8'h49);
		pbm_mac_model_i.send(pkt, 4, 4'h2);
		repeat (20) @(posedge clk);
		rd(PBM_OFF_RXMODE, 8'h09);
		wr(PBM_OFF_SKIP, 8'h04);
		repeat (30) @(posedge clk);
		rd(PBM_OFF_SKIP, 8'h00);
		rd(PBM_OFF_RXMODE, 8'h49);
		wr(PBM_OFF_RXMODE, 8'h01);
		pbm_mac_model_i.send(pkt, 4, 4'h2);
		repeat (20) @(posedge clk);
		rd(PBM_OFF_RXMODE, 8'h41);
		`CHK(expT.size(), 0)
		`CHK(rxStopped, 1'h0)
		$display("receive test done");
		test_done();
	end
endmodule
